// ==== include/sor_pkg.sv ====
// Constants, field layouts and carrier types of the system options and periodic timer block.
package sor_pkg;

    // ----------------------------------------------------------------
    // Register map and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_OPTIONS = 8'h00;
    localparam logic [7:0] OFS_ID_HIGH = 8'h04;
    localparam logic [7:0] OFS_ID_LOW = 8'h08;
    localparam logic [7:0] OFS_TIMER = 8'h0c;

    localparam int OPT_WDOG_EN_BIT = 7;
    localparam int OPT_WDOG_LONG_BIT = 6;
    localparam int OPT_STOP_BIT = 5;
    localparam int OPT_DEBUG_PIN_BIT = 1;
    localparam int OPT_RESET_PIN_BIT = 0;

    localparam int TMR_FLAG_BIT = 7;
    localparam int TMR_ACK_BIT = 6;
    localparam int TMR_CLKSEL_BIT = 5;
    localparam int TMR_IRQEN_BIT = 4;

    // Reset values of the options fields; the debug pin enable is loaded later from straps.
    localparam logic OPT_WDOG_EN_RESET = 1'h1;
    localparam logic OPT_WDOG_LONG_RESET = 1'h1;
    localparam logic OPT_STOP_RESET = 1'h0;
    localparam logic OPT_DEBUG_PIN_RESET = 1'h1;
    localparam logic OPT_RESET_PIN_RESET = 1'h0;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int EXT_DIV = 32;
    localparam logic [8:0] WDOG_SHORT_TICKS = 9'h020;
    localparam logic [8:0] WDOG_LONG_TICKS = 9'h100;

    // Period in source ticks (1 ms oscillator ticks, or 32 external reference edges) for each period select value; zero means stopped.
    function automatic logic [10:0] sor_period_ticks(input logic [2:0] sel);
        case (sel)
            3'h1: sor_period_ticks = 11'h008;
            3'h2: sor_period_ticks = 11'h020;
            3'h3: sor_period_ticks = 11'h040;
            3'h4: sor_period_ticks = 11'h080;
            3'h5: sor_period_ticks = 11'h100;
            3'h6: sor_period_ticks = 11'h200;
            3'h7: sor_period_ticks = 11'h400;
            default: sor_period_ticks = 11'h000;
        endcase
    endfunction : sor_period_ticks

    // ----------------------------------------------------------------
    // Carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic watchdog_enable;
        logic watchdog_long_timeout;
        logic stop_permit;
        logic debug_pin_enable;
        logic reset_pin_enable;
    } sor_options_type;

    typedef struct packed {
        logic periodic_timeout_flag;
        logic periodic_clock_select;
        logic periodic_irq_enable;
        logic [2:0] periodic_period_select;
    } sor_timer_type;

endpackage : sor_pkg

// ==== src/sor_top.sv ====
// System options register, part identification and periodic wakeup timer behind APB.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
module sor_top #(
    parameter logic [11:0] PART_ID = 12'h5a3,
    parameter int EXT_DIVIDE = sor_pkg::EXT_DIV
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mode_select_pin,
    input wire logic security_disengaged,
    input wire logic osc_1khz,
    input wire logic ext_ref_clk,
    input wire logic stop_mode,
    input wire logic low_voltage_stop_ok,
    input wire logic stop_exec,
    input wire logic watchdog_service,
    output logic watchdog_reset,
    output logic illegal_opcode_reset,
    output logic stop_enter,
    output logic debug_pin_select,
    output logic reset_pin_select,
    output logic reset_pin_pullup,
    output logic periodic_irq
);

    // PART_ID default is arbitrary and names no real part.
    // The prescaler is five bits wide, so only a divide by 32 can be served.
    if (EXT_DIVIDE != 32)
    begin : gen_divide_check
        $error("EXT_DIVIDE must be 32.");
    end

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Bit 0 mode select, 1 security, 2 oscillator, 3 external reference.
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] sync3_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            sync3_q <= 4'h0;
        end
        else
        begin
            sync1_q <= {ext_ref_clk, osc_1khz, security_disengaged, mode_select_pin};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    logic osc_tick;
    logic ext_edge;
    logic ext_running;
    assign osc_tick = sync2_q[2] & ~sync3_q[2];
    assign ext_edge = sync2_q[3] & ~sync3_q[3];
    assign ext_running = ~stop_mode | low_voltage_stop_ok;

    // ----------------------------------------------------------------
    // Strap capture and bus slave
    // ----------------------------------------------------------------
    // The strap pins need two edges through the synchroniser, so the bus is held off until
    // registered read data already shows the debug pin enable's real reset value.
    typedef enum {SOR_SYNC0, SOR_SYNC1, SOR_LOAD, SOR_RUN} sor_state_type;
    sor_state_type state_q, state_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    sor_pkg::sor_options_type opt_q, opt_d;
    logic locked_q, locked_d;
    sor_pkg::sor_timer_type tmr_q, tmr_d;

    logic opt_write;
    logic tmr_write;
    logic mapped;
    assign mapped = (paddr == sor_pkg::OFS_OPTIONS) || (paddr == sor_pkg::OFS_ID_HIGH)
        || (paddr == sor_pkg::OFS_ID_LOW) || (paddr == sor_pkg::OFS_TIMER);
    assign opt_write = psel & penable & pwrite & pready_q & (paddr == sor_pkg::OFS_OPTIONS);
    assign tmr_write = psel & penable & pwrite & pready_q & (paddr == sor_pkg::OFS_TIMER);

    always_comb
    begin
        state_d = state_q;
        pready_d = pready_q;
        pslverr_d = 1'h0;
        prdata_d = 32'h0;
        case (state_q)
            SOR_SYNC0: state_d = SOR_SYNC1;
            SOR_SYNC1: state_d = SOR_LOAD;
            SOR_LOAD: state_d = SOR_RUN;
            SOR_RUN:
            begin
                state_d = SOR_RUN;
                pready_d = 1'h1;
            end
            default: state_d = SOR_SYNC0;
        endcase
        if (psel && !pwrite)
        begin
            case (paddr)
                sor_pkg::OFS_OPTIONS:
                    prdata_d = {24'h0, opt_q.watchdog_enable, opt_q.watchdog_long_timeout,
                        opt_q.stop_permit, 3'h0, opt_q.debug_pin_enable,
                        opt_q.reset_pin_enable};
                sor_pkg::OFS_ID_HIGH: prdata_d = {28'h0, PART_ID[11:8]};
                sor_pkg::OFS_ID_LOW: prdata_d = {24'h0, PART_ID[7:0]};
                sor_pkg::OFS_TIMER:
                    prdata_d = {24'h0, tmr_q.periodic_timeout_flag, 1'h0,
                        tmr_q.periodic_clock_select, tmr_q.periodic_irq_enable, 1'h0,
                        tmr_q.periodic_period_select};
                default: prdata_d = 32'h0;
            endcase
        end
        if (psel && !mapped)
            pslverr_d = 1'h1;
    end

    // ----------------------------------------------------------------
    // System options
    // ----------------------------------------------------------------
    always_comb
    begin
        opt_d = opt_q;
        locked_d = locked_q;
        if (state_q == SOR_LOAD)
        begin
            opt_d.debug_pin_enable = ~sync2_q[0] | sync2_q[1];
        end
        if (opt_write && !locked_q)
        begin
            locked_d = 1'h1;
            opt_d.watchdog_enable = pwdata[sor_pkg::OPT_WDOG_EN_BIT];
            opt_d.watchdog_long_timeout = pwdata[sor_pkg::OPT_WDOG_LONG_BIT];
            opt_d.stop_permit = pwdata[sor_pkg::OPT_STOP_BIT];
            opt_d.debug_pin_enable = opt_q.debug_pin_enable
                & pwdata[sor_pkg::OPT_DEBUG_PIN_BIT];
            opt_d.reset_pin_enable = pwdata[sor_pkg::OPT_RESET_PIN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= SOR_SYNC0;
            pready_q <= 1'h0;
            pslverr_q <= 1'h0;
            prdata_q <= 32'h0;
            opt_q <= '{sor_pkg::OPT_WDOG_EN_RESET, sor_pkg::OPT_WDOG_LONG_RESET,
                sor_pkg::OPT_STOP_RESET, sor_pkg::OPT_DEBUG_PIN_RESET,
                sor_pkg::OPT_RESET_PIN_RESET};
            locked_q <= 1'h0;
        end
        else
        begin
            state_q <= state_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
            opt_q <= opt_d;
            locked_q <= locked_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign debug_pin_select = opt_q.debug_pin_enable;
    assign reset_pin_select = opt_q.reset_pin_enable;
    assign reset_pin_pullup = opt_q.reset_pin_enable;

    // ----------------------------------------------------------------
    // Watchdog and stop control
    // ----------------------------------------------------------------
    logic [8:0] wd_cnt_q, wd_cnt_d;
    logic wd_reset_q, wd_reset_d;
    logic illegal_q, illegal_d;
    logic stop_enter_q, stop_enter_d;
    logic [8:0] wd_limit;

    assign wd_limit = opt_q.watchdog_long_timeout ? sor_pkg::WDOG_LONG_TICKS
        : sor_pkg::WDOG_SHORT_TICKS;

    always_comb
    begin
        wd_cnt_d = wd_cnt_q;
        wd_reset_d = 1'h0;
        if (!opt_q.watchdog_enable || watchdog_service)
            wd_cnt_d = 9'h000;
        else if (osc_tick)
        begin
            if (wd_cnt_q + 9'h001 >= wd_limit)
            begin
                wd_cnt_d = 9'h000;
                wd_reset_d = 1'h1;
            end
            else
                wd_cnt_d = wd_cnt_q + 9'h001;
        end
        stop_enter_d = stop_exec & opt_q.stop_permit;
        illegal_d = stop_exec & ~opt_q.stop_permit;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wd_cnt_q <= 9'h000;
            wd_reset_q <= 1'h0;
            illegal_q <= 1'h0;
            stop_enter_q <= 1'h0;
        end
        else
        begin
            wd_cnt_q <= wd_cnt_d;
            wd_reset_q <= wd_reset_d;
            illegal_q <= illegal_d;
            stop_enter_q <= stop_enter_d;
        end
    end

    assign watchdog_reset = wd_reset_q;
    assign illegal_opcode_reset = illegal_q;
    assign stop_enter = stop_enter_q;

    // ----------------------------------------------------------------
    // Periodic wakeup timer
    // ----------------------------------------------------------------
    logic [4:0] pre_q, pre_d;
    logic [10:0] cnt_q, cnt_d;
    logic irq_q, irq_d;
    logic timeout;
    logic src_tick;
    logic [10:0] period;

    assign period = sor_pkg::sor_period_ticks(tmr_q.periodic_period_select);

    always_comb
    begin
        tmr_d = tmr_q;
        pre_d = pre_q;
        cnt_d = cnt_q;
        timeout = 1'h0;
        src_tick = 1'h0;
        if (ext_edge && ext_running)
        begin
            pre_d = pre_q + 5'h01;
            src_tick = tmr_q.periodic_clock_select && (pre_q == 5'h1f);
        end
        if (!tmr_q.periodic_clock_select)
            src_tick = osc_tick;
        if (period == 11'h000)
            cnt_d = 11'h000;
        else if (src_tick)
        begin
            if (cnt_q + 11'h001 >= period)
            begin
                cnt_d = 11'h000;
                timeout = 1'h1;
            end
            else
                cnt_d = cnt_q + 11'h001;
        end
        if (tmr_write)
        begin
            tmr_d.periodic_clock_select = pwdata[sor_pkg::TMR_CLKSEL_BIT];
            tmr_d.periodic_irq_enable = pwdata[sor_pkg::TMR_IRQEN_BIT];
            tmr_d.periodic_period_select = pwdata[2:0];
            if (pwdata[2:0] != tmr_q.periodic_period_select
                || pwdata[sor_pkg::TMR_CLKSEL_BIT] != tmr_q.periodic_clock_select)
            begin
                cnt_d = 11'h000;
                pre_d = 5'h00;
            end
            if (pwdata[sor_pkg::TMR_ACK_BIT])
                tmr_d.periodic_timeout_flag = 1'h0;
        end
        if (timeout)
            tmr_d.periodic_timeout_flag = 1'h1;
        irq_d = tmr_d.periodic_timeout_flag & tmr_d.periodic_irq_enable;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tmr_q <= '{1'h0, 1'h0, 1'h0, 3'h0};
            pre_q <= 5'h00;
            cnt_q <= 11'h000;
            irq_q <= 1'h0;
        end
        else
        begin
            tmr_q <= tmr_d;
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            irq_q <= irq_d;
        end
    end

    assign periodic_irq = irq_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence sor_opt_write_locked_s;
        locked_q && opt_write;
    endsequence

    sequence sor_strap_load_s;
        state_q == SOR_LOAD;
    endsequence

    AST_WRITE_ONCE: assert property (
        @(posedge pclk) disable iff (!presetn)
        sor_opt_write_locked_s |=> $stable(opt_q))
        else $error("Options register changed after its first write.");

    AST_STRAP_NORMAL: assert property (
        @(posedge pclk) disable iff (!presetn)
        sor_strap_load_s and sync2_q[0] |=> opt_q.debug_pin_enable == $past(sync2_q[1]))
        else $error("Debug pin enable does not follow security in normal boot.");

    AST_STRAP_DEBUG: assert property (
        @(posedge pclk) disable iff (!presetn)
        sor_strap_load_s and !sync2_q[0] |=> opt_q.debug_pin_enable)
        else $error("Debug pin enable not set in debug boot.");

    AST_DEBUG_NO_RISE: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_q == SOR_RUN && !opt_q.debug_pin_enable |=> !opt_q.debug_pin_enable)
        else $error("Debug pin enable rose outside reset.");

    AST_WDOG_FIRE: assert property (
        @(posedge pclk) disable iff (!presetn)
        opt_q.watchdog_enable && !watchdog_service && osc_tick
            && wd_cnt_q == wd_limit - 9'h001 |=> watchdog_reset ##1 !watchdog_reset)
        else $error("Watchdog did not fire a single pulse at its limit.");

    AST_WDOG_LIMIT: assert property (
        @(posedge pclk) disable iff (!presetn)
        wd_cnt_q < wd_limit || !opt_q.watchdog_enable)
        else $error("Watchdog count passed the selected timeout.");

    AST_STOP_ILLEGAL: assert property (
        @(posedge pclk) disable iff (!presetn)
        stop_exec && !opt_q.stop_permit |=> illegal_opcode_reset && !stop_enter)
        else $error("Stop without permission did not force illegal opcode reset.");

    AST_FLAG_SET: assert property (
        @(posedge pclk) disable iff (!presetn)
        timeout |=> tmr_q.periodic_timeout_flag)
        else $error("Timeout did not set the flag.");

    AST_ACK_CLEAR: assert property (
        @(posedge pclk) disable iff (!presetn)
        tmr_write && pwdata[sor_pkg::TMR_ACK_BIT] && !timeout
            |=> !tmr_q.periodic_timeout_flag && !periodic_irq)
        else $error("Acknowledge did not clear flag and request.");

    AST_DISABLED: assert property (
        @(posedge pclk) disable iff (!presetn)
        tmr_q.periodic_period_select == 3'h0 |-> !timeout && cnt_q == 11'h000)
        else $error("Disabled timer still counting.");

    AST_IRQ_LEVEL: assert property (
        @(posedge pclk) disable iff (!presetn)
        periodic_irq == (tmr_q.periodic_timeout_flag && tmr_q.periodic_irq_enable))
        else $error("Interrupt request does not match flag and enable.");

endmodule : sor_top

// ==== tb/test_sor_top.sv ====
// Self-checking testbench of the system options and periodic timer block.
`timescale 1ns/1ps
module test_sor_top;
    // ----------------------------------------------------------------
    // Signals and instance
    // ----------------------------------------------------------------
    // Arbitrary part number, chosen only for this bench.
    localparam logic [11:0] BENCH_ID = 12'h3c7;
    logic pclk, presetn, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, mode_select_pin, security_disengaged, osc_1khz, ext_ref_clk;
    logic stop_mode, low_voltage_stop_ok, stop_exec, watchdog_service, watchdog_reset;
    logic illegal_opcode_reset, stop_enter, debug_pin_select, reset_pin_select;
    logic reset_pin_pullup, periodic_irq;
    logic [32:0] exp_q[$];
    int miscompares = 0;
    int n_tests = 0;
    int wd_pulses = 0;

    sor_top #(.PART_ID(BENCH_ID)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mode_select_pin(mode_select_pin),
        .security_disengaged(security_disengaged), .osc_1khz(osc_1khz),
        .ext_ref_clk(ext_ref_clk), .stop_mode(stop_mode),
        .low_voltage_stop_ok(low_voltage_stop_ok), .stop_exec(stop_exec),
        .watchdog_service(watchdog_service), .watchdog_reset(watchdog_reset),
        .illegal_opcode_reset(illegal_opcode_reset), .stop_enter(stop_enter),
        .debug_pin_select(debug_pin_select), .reset_pin_select(reset_pin_select),
        .reset_pin_pullup(reset_pin_pullup), .periodic_irq(periodic_irq));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // The slow sources run fast so that long periods fit a short run.
    initial
    begin
        osc_1khz = 1'b0;
        forever
        begin
            repeat (4) @(posedge pclk);
            osc_1khz <= ~osc_1khz;
        end
    end

    initial
    begin
        ext_ref_clk = 1'b0;
        forever
        begin
            repeat (2) @(posedge pclk);
            ext_ref_clk <= ~ext_ref_clk;
        end
    end

    // ----------------------------------------------------------------
    // Compare tasks and bus cycles
    // ----------------------------------------------------------------
    task automatic check_read(input logic [32:0] exp, input logic [32:0] got);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value read_word expected %h seen %h", exp, got);
        end
    endtask : check_read

    task automatic check_bit(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask : check_bit

    task automatic check_span(input string name, input int lo, input int hi, input int got);
        n_tests++;
        if (got < lo || got > hi)
        begin
            miscompares++;
            $display("wrong value %s expected %0d to %0d seen %0d", name, lo, hi, got);
        end
    endtask : check_span

    task automatic conclude;
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    // The request stands until the edge at which pready is seen high.
    task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer

    task automatic apb_write(input logic [7:0] a, input logic [31:0] d);
        apb_xfer(1'b1, a, d);
    endtask : apb_write

    task automatic apb_read(input logic [7:0] a, input logic [31:0] exp, input logic err);
        exp_q.push_back({err, exp});
        apb_xfer(1'b0, a, 32'h0);
    endtask : apb_read

    task automatic do_reset(input logic ms, input logic sd);
        @(posedge pclk);
        presetn <= 1'b0;
        mode_select_pin <= ms;
        security_disengaged <= sd;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    task automatic wait_irq(output int n);
        n = 0;
        // The first look is one edge late, so a request still being acknowledged is not seen.
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (periodic_irq !== 1'b1 && n < 9000);
    endtask : wait_irq

    task automatic pulse_stop;
        @(posedge pclk);
        stop_exec <= 1'b1;
        @(posedge pclk);
        stop_exec <= 1'b0;
        #1;
    endtask : pulse_stop

    always @(posedge pclk)
    begin
        if (watchdog_reset === 1'b1)
            wd_pulses++;
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
        begin
            if (exp_q.size() == 0)
                check_span("read_queue", 1, 1, 0);
            else
                check_read(exp_q.pop_front(), {pslverr, prdata});
        end
    end

    initial
    begin
        repeat (50000) @(posedge pclk);
        miscompares++;
        conclude();
    end

    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial
    begin
        logic [7:0] v;
        logic [2:0] sel;
        logic dbg;
        int n;
        int wd0;
        int tk;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {mode_select_pin, security_disengaged, stop_mode, low_voltage_stop_ok} = '0;
        {stop_exec, watchdog_service} = '0;
        void'($urandom(32'h4b2021e1));
        for (int i = 0; i < 4; i++)
        begin
            dbg = ~i[1] | i[0];
            do_reset(i[1], i[0]);
            apb_read(sor_pkg::OFS_OPTIONS, {24'h0, 6'h30, dbg, 1'b0}, 1'b0);
            check_bit("debug_pin_select", dbg, debug_pin_select);
            check_bit("reset_pin_select", 1'b0, reset_pin_select);
        end
        apb_write(sor_pkg::OFS_ID_HIGH, 32'hff);
        apb_write(sor_pkg::OFS_ID_LOW, 32'h0);
        apb_read(sor_pkg::OFS_ID_HIGH, {28'h0, BENCH_ID[11:8]}, 1'b0);
        apb_read(sor_pkg::OFS_ID_LOW, {24'h0, BENCH_ID[7:0]}, 1'b0);
        apb_read(sor_pkg::OFS_TIMER, 32'h0, 1'b0);
        apb_write(8'h10, 32'h5a);
        apb_read(8'h10, 32'h0, 1'b1);
        for (int j = 0; j < 2; j++)
        begin
            do_reset(1'b1, 1'b1);
            v = 8'($urandom());
            v[5] = j[0];
            v[4:2] = 3'h0;
            apb_write(sor_pkg::OFS_OPTIONS, {24'h0, v});
            apb_write(sor_pkg::OFS_OPTIONS, {24'h0, ~v});
            apb_read(sor_pkg::OFS_OPTIONS, {24'h0, v}, 1'b0);
            #1;
            check_bit("debug_pin_select", v[1], debug_pin_select);
            check_bit("reset_pin_select", v[0], reset_pin_select);
            check_bit("reset_pin_pullup", v[0], reset_pin_pullup);
            pulse_stop();
            check_bit("illegal_opcode_reset", ~v[5], illegal_opcode_reset);
            check_bit("stop_enter", v[5], stop_enter);
        end
        do_reset(1'b1, 1'b0);
        apb_write(sor_pkg::OFS_OPTIONS, 32'h03);
        apb_read(sor_pkg::OFS_OPTIONS, 32'h01, 1'b0);
        check_bit("debug_pin_select", 1'b0, debug_pin_select);
        for (int m = 0; m < 2; m++)
        begin
            do_reset(1'b1, 1'b1);
            apb_write(sor_pkg::OFS_OPTIONS, {24'h0, 1'b1, m[0], 6'h0});
            @(posedge pclk);
            watchdog_service <= 1'b1;
            @(posedge pclk);
            watchdog_service <= 1'b0;
            n = 0;
            while (watchdog_reset !== 1'b1 && n < 2400)
            begin
                @(posedge pclk);
                n++;
            end
            // Short is 32 ticks, long 256 ticks, of 8 cycles each.
            tk = m ? 2048 : 256;
            check_span("watchdog_period", tk - 12, tk + 12, n);
        end
        do_reset(1'b1, 1'b1);
        apb_write(sor_pkg::OFS_OPTIONS, 32'h20);
        wd0 = wd_pulses;
        repeat (600) @(posedge pclk);
        check_span("watchdog_off", wd0, wd0, wd_pulses);
        for (int k = 1; k < 8; k++)
        begin
            sel = k[2:0];
            apb_write(sor_pkg::OFS_TIMER, {24'h0, 5'h0a, sel});
            wait_irq(n);
            // A tick is 8 cycles here; periods are 8 ticks, then 32 ticks doubling.
            tk = (k == 1) ? 64 : (64 << k);
            check_span("period_osc", tk - 12, tk + 12, n);
            apb_read(sor_pkg::OFS_TIMER, {24'h0, 5'h12, sel}, 1'b0);
            apb_write(sor_pkg::OFS_TIMER, {24'h0, 5'h0a, sel});
            #1;
            check_bit("periodic_irq", 1'b0, periodic_irq);
            apb_read(sor_pkg::OFS_TIMER, {24'h0, 5'h02, sel}, 1'b0);
        end
        apb_write(sor_pkg::OFS_TIMER, 32'h71);
        wait_irq(n);
        check_span("period_ext", 1012, 1036, n);
        apb_write(sor_pkg::OFS_TIMER, 32'h72);
        wait_irq(n);
        check_span("period_ext", 4084, 4108, n);
        apb_write(sor_pkg::OFS_TIMER, 32'h41);
        repeat (120) @(posedge pclk);
        check_bit("periodic_irq", 1'b0, periodic_irq);
        apb_read(sor_pkg::OFS_TIMER, 32'h81, 1'b0);
        apb_write(sor_pkg::OFS_TIMER, 32'h40);
        // A timeout in the cycle of the first write would win over its acknowledge.
        apb_write(sor_pkg::OFS_TIMER, 32'h40);
        repeat (200) @(posedge pclk);
        apb_read(sor_pkg::OFS_TIMER, 32'h00, 1'b0);
        stop_mode <= 1'b1;
        apb_write(sor_pkg::OFS_TIMER, 32'h71);
        repeat (1300) @(posedge pclk);
        check_bit("periodic_irq", 1'b0, periodic_irq);
        low_voltage_stop_ok <= 1'b1;
        wait_irq(n);
        check_span("period_stop", 1012, 1036, n);
        conclude();
    end
endmodule : test_sor_top
